// ---- hw/dcd_pkg.sv ----
package dcd_pkg;

   // ==========================================================
   // protocol classes
   localparam logic [2:0] DCD_CLS_NONE     = 3'h0;
   localparam logic [2:0] DCD_CLS_PIO_IN   = 3'h1;
   localparam logic [2:0] DCD_CLS_PIO_OUT  = 3'h2;
   localparam logic [2:0] DCD_CLS_NODATA   = 3'h3;
   localparam logic [2:0] DCD_CLS_DMA      = 3'h4;
   localparam logic [2:0] DCD_CLS_FPDMA    = 3'h5;

   // ==========================================================
   // opcodes with subcodes and the seek and recalibrate nibbles
   localparam logic [7:0] DCD_OP_HEALTH    = 8'hb0;
   localparam logic [7:0] DCD_OP_FEATURES  = 8'hef;
   localparam logic [3:0] DCD_OP_SEEK_HI   = 4'h7;
   localparam logic [3:0] DCD_OP_RECAL_HI  = 4'h1;

   // health subcodes
   localparam logic [7:0] DCD_HS_RD_ATTR   = 8'hd0;
   localparam logic [7:0] DCD_HS_RD_THR    = 8'hd1;
   localparam logic [7:0] DCD_HS_AUTOSAVE  = 8'hd2;
   localparam logic [7:0] DCD_HS_SAVE      = 8'hd3;
   localparam logic [7:0] DCD_HS_OFFLINE   = 8'hd4;
   localparam logic [7:0] DCD_HS_RD_LOG    = 8'hd5;
   localparam logic [7:0] DCD_HS_WR_LOG    = 8'hd6;
   localparam logic [7:0] DCD_HS_ENABLE    = 8'hd8;
   localparam logic [7:0] DCD_HS_DISABLE   = 8'hd9;
   localparam logic [7:0] DCD_HS_STATUS    = 8'hda;
   localparam logic [7:0] DCD_HS_AUTO_OFF  = 8'hdb;

   // feature subcodes
   localparam logic [7:0] DCD_FS_WC_EN     = 8'h02;
   localparam logic [7:0] DCD_FS_XFER      = 8'h03;
   localparam logic [7:0] DCD_FS_APM_EN    = 8'h05;
   localparam logic [7:0] DCD_FS_PUIS_EN   = 8'h06;
   localparam logic [7:0] DCD_FS_SPINUP    = 8'h07;
   localparam logic [7:0] DCD_FS_AOM_EN    = 8'h09;
   localparam logic [7:0] DCD_FS_AAM_EN    = 8'h42;
   localparam logic [7:0] DCD_FS_RLA_DIS   = 8'h55;
   localparam logic [7:0] DCD_FS_REV_DIS   = 8'h66;
   localparam logic [7:0] DCD_FS_WC_DIS    = 8'h82;
   localparam logic [7:0] DCD_FS_APM_DIS   = 8'h85;
   localparam logic [7:0] DCD_FS_PUIS_DIS  = 8'h86;
   localparam logic [7:0] DCD_FS_AOM_DIS   = 8'h89;
   localparam logic [7:0] DCD_FS_RLA_EN    = 8'haa;
   localparam logic [7:0] DCD_FS_AAM_DIS   = 8'hc2;
   localparam logic [7:0] DCD_FS_REV_EN    = 8'hcc;

   // ==========================================================
   // device/head and register bits
   localparam int         DCD_DH_LBA_BIT   = 6;
   localparam int         DCD_DH_DEV_BIT   = 4;
   localparam logic [7:0] DCD_ERR_ABORT    = 8'h04;
   localparam logic [7:0] DCD_ST_READY     = 8'h40;
   localparam logic [7:0] DCD_ST_ERROR     = 8'h01;

   // feature bit positions in the settings vector
   localparam int DCD_SET_WC   = 0;
   localparam int DCD_SET_APM  = 1;
   localparam int DCD_SET_AAM  = 2;
   localparam int DCD_SET_RLA  = 3;
   localparam int DCD_SET_REV  = 4;
   localparam int DCD_SET_PUIS = 5;
   localparam int DCD_SET_AOM  = 6;
   localparam int DCD_SET_HLTH = 7;
   localparam logic [7:0] DCD_SET_RESET = 8'h18;

   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] feature;
      logic [7:0] devhead;
   } dcd_cmd_t;

   typedef struct packed {
      logic [2:0] cls;
      logic       lba;
      logic [3:0] head;
      logic       abort;
      logic       seek;
      logic       spinup;
      logic       xfer_mode;
      logic       hs_op;
   } dcd_dec_t;

endpackage

// ---- hw/dcd_classify.sv ----
`timescale 1ns/100ps
// combinational opcode and subcode classifier
module dcd_classify
   import dcd_pkg::*;
(
   input  wire dcd_cmd_t cmd,
   output dcd_dec_t      dec
);

   // ==========================================================
   // opcode class table
   function automatic logic [2:0] op_class(input logic [7:0] op);
      logic [2:0] c;
      c = DCD_CLS_NONE;
      if (op[7:4] == DCD_OP_SEEK_HI || op[7:4] == DCD_OP_RECAL_HI) begin
         c = DCD_CLS_NODATA;
      end else begin
         case (op)
            8'he5, 8'h98, 8'h51, 8'hb1, 8'h90, 8'he7, 8'hea, 8'he3, 8'h97, 8'he1, 8'h95, 8'h91,
            8'hf8, 8'h27, 8'h40, 8'h41, 8'h42, 8'hf3, 8'hf5, 8'hef, 8'hf9, 8'h37, 8'hc6,
            8'he6, 8'h99, 8'he2, 8'h96, 8'he0, 8'h94, 8'h45, 8'hb0:
               c = DCD_CLS_NODATA;
            8'hec, 8'he4, 8'h2f, 8'hc4, 8'h29, 8'h20, 8'h21, 8'h24:
               c = DCD_CLS_PIO_IN;
            8'h92, 8'h50, 8'hf6, 8'hf4, 8'hf1, 8'hf2, 8'he8, 8'h3f, 8'hc5, 8'h39, 8'hce, 8'h30,
            8'h31, 8'h34:
               c = DCD_CLS_PIO_OUT;
            8'hc8, 8'hc9, 8'h25, 8'h2a, 8'h2b, 8'hca, 8'hcb, 8'h35, 8'h3d, 8'h3a, 8'h3b:
               c = DCD_CLS_DMA;
            8'h60, 8'h61:
               c = DCD_CLS_FPDMA;
            default:
               c = DCD_CLS_NONE;
         endcase
      end
      return c;
   endfunction

   logic [2:0] c0;

   always_comb begin
      c0            = op_class(cmd.opcode);
      dec           = '0;
      dec.cls       = c0;
      dec.lba       = cmd.devhead[DCD_DH_LBA_BIT];
      dec.head      = cmd.devhead[3:0];
      dec.seek      = (cmd.opcode[7:4] == DCD_OP_SEEK_HI);
      dec.abort     = (c0 == DCD_CLS_NONE);
      if (cmd.opcode == DCD_OP_HEALTH) begin
         dec.hs_op = 1'b1;
         case (cmd.feature)
            DCD_HS_RD_ATTR, DCD_HS_RD_THR, DCD_HS_RD_LOG:
               dec.cls = DCD_CLS_PIO_IN;
            DCD_HS_WR_LOG:
               dec.cls = DCD_CLS_PIO_OUT;
            DCD_HS_AUTOSAVE, DCD_HS_SAVE, DCD_HS_OFFLINE, DCD_HS_ENABLE, DCD_HS_DISABLE,
            DCD_HS_STATUS, DCD_HS_AUTO_OFF:
               dec.cls = DCD_CLS_NODATA;
            default: begin
               dec.cls   = DCD_CLS_NONE;
               dec.abort = 1'b1;
            end
         endcase
      end else if (cmd.opcode == DCD_OP_FEATURES) begin
         case (cmd.feature)
            DCD_FS_WC_EN, DCD_FS_APM_EN, DCD_FS_PUIS_EN, DCD_FS_AOM_EN, DCD_FS_AAM_EN,
            DCD_FS_RLA_DIS, DCD_FS_REV_DIS, DCD_FS_WC_DIS, DCD_FS_APM_DIS, DCD_FS_PUIS_DIS,
            DCD_FS_AOM_DIS, DCD_FS_RLA_EN, DCD_FS_AAM_DIS, DCD_FS_REV_EN: ;
            DCD_FS_XFER:   dec.xfer_mode = 1'b1;
            DCD_FS_SPINUP: dec.spinup    = 1'b1;
            default: begin
               dec.cls   = DCD_CLS_NONE;
               dec.abort = 1'b1;
            end
         endcase
      end
   end

endmodule

// ---- hw/dcd_decoder.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// - tag each known opcode with protocol class 1..5, unknown ones 0 with abort
// - legacy alternate opcodes act as primaries
// - recognise all write family opcodes
// - seek matches upper nibble 7 only
// - B0 selects health function by subcode
// - health D0 D1 D5 are data in
// - health D2 D3 D6 D8 D9 DB mapped
// - EF 05/85 enable/disable power management
// - EF 42/C2 enable/disable acoustic management
// - EF 55/AA disable/enable read look-ahead
// - EF 66/CC stop/restore reverting to defaults
// - EF 06/86 standby power-up, 07 spin-up
// - EF 09/89 offset mode, 02/82 cache, 03
// - device select bit ignored, act device 0
// - addressing bit: 0 chs, 1 lba
// - retry bit has no effect
// - valid result bits and head returned
// - status and error shown with completion
module dcd_decoder
   import dcd_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       nrst,
   input  wire logic       cmd_valid,
   input  wire dcd_cmd_t   cmd,
   input  wire logic [7:0] result_count,
   input  wire logic       done,
   output dcd_dec_t        dec,
   output logic            dec_valid,
   output logic            busy,
   output logic [7:0]      settings,
   output logic [7:0]      status,
   output logic [7:0]      error,
   output logic [7:0]      count_out,
   output logic [7:0]      devhead_out,
   output logic            irq
);

   // ==========================================================
   // reset release
   logic rst_m_q;
   logic rst_n_q;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rst_m_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_n_q <= rst_m_q;
      end
   end

   // ==========================================================
   // decode
   dcd_dec_t dec_w;
   dcd_cmd_t cmd_q;

   dcd_classify u_cls (
      .cmd (cmd_q),
      .dec (dec_w)
   );

   typedef enum logic [1:0] {DCD_IDLE, DCD_DECODE, DCD_EXEC} dcd_state_t;

   dcd_state_t state_q, state_d;
   dcd_cmd_t   cmd_d;
   dcd_dec_t   dec_q, dec_d;
   logic       dv_q, dv_d;
   logic [7:0] set_q, set_d;
   logic [7:0] st_q, st_d;
   logic [7:0] er_q, er_d;
   logic [7:0] cnt_q, cnt_d;
   logic [7:0] dh_q, dh_d;
   logic       irq_q, irq_d;

   // feature setting update, one bit per on/off subcode pair
   function automatic logic [7:0] apply_feature(input logic [7:0] s, input logic [7:0] f);
      logic [7:0] r;
      r = s;
      case (f)
         DCD_FS_WC_EN:    r[DCD_SET_WC]   = 1'b1;
         DCD_FS_WC_DIS:   r[DCD_SET_WC]   = 1'b0;
         DCD_FS_APM_EN:   r[DCD_SET_APM]  = 1'b1;
         DCD_FS_APM_DIS:  r[DCD_SET_APM]  = 1'b0;
         DCD_FS_AAM_EN:   r[DCD_SET_AAM]  = 1'b1;
         DCD_FS_AAM_DIS:  r[DCD_SET_AAM]  = 1'b0;
         DCD_FS_RLA_DIS:  r[DCD_SET_RLA]  = 1'b0;
         DCD_FS_RLA_EN:   r[DCD_SET_RLA]  = 1'b1;
         DCD_FS_REV_DIS:  r[DCD_SET_REV]  = 1'b0;
         DCD_FS_REV_EN:   r[DCD_SET_REV]  = 1'b1;
         DCD_FS_PUIS_EN:  r[DCD_SET_PUIS] = 1'b1;
         DCD_FS_PUIS_DIS: r[DCD_SET_PUIS] = 1'b0;
         DCD_FS_AOM_EN:   r[DCD_SET_AOM]  = 1'b1;
         DCD_FS_AOM_DIS:  r[DCD_SET_AOM]  = 1'b0;
         default:         r = s;
      endcase
      return r;
   endfunction

   always_comb begin
      state_d = state_q;
      cmd_d   = cmd_q;
      dec_d   = dec_q;
      dv_d    = 1'b0;
      set_d   = set_q;
      st_d    = st_q;
      er_d    = er_q;
      cnt_d   = cnt_q;
      dh_d    = dh_q;
      irq_d   = 1'b0;
      case (state_q)
         DCD_IDLE: begin
            if (cmd_valid) begin
               cmd_d = cmd;
               // device select and retry bits carry no meaning here
               cmd_d.devhead[DCD_DH_DEV_BIT] = 1'b0;
               state_d = DCD_DECODE;
            end
         end
         DCD_DECODE: begin
            dec_d = dec_w;
            dv_d  = 1'b1;
            if (dec_w.abort) begin
               // abort completes at once, nothing executes
               er_d    = DCD_ERR_ABORT;
               st_d    = DCD_ST_READY | DCD_ST_ERROR;
               irq_d   = 1'b1;
               state_d = DCD_IDLE;
            end else begin
               if (cmd_q.opcode == DCD_OP_FEATURES) begin
                  set_d = apply_feature(set_q, cmd_q.feature);
               end
               if (dec_w.hs_op && cmd_q.feature == DCD_HS_ENABLE) begin
                  set_d[DCD_SET_HLTH] = 1'b1;
               end else if (dec_w.hs_op && cmd_q.feature == DCD_HS_DISABLE) begin
                  set_d[DCD_SET_HLTH] = 1'b0;
               end
               state_d = DCD_EXEC;
            end
         end
         DCD_EXEC: begin
            if (done) begin
               // final registers change only together with completion
               er_d    = '0;
               st_d    = DCD_ST_READY;
               cnt_d   = result_count;
               dh_d    = {cmd_q.devhead[7:5], 1'b0, dec_q.head};
               irq_d   = 1'b1;
               state_d = DCD_IDLE;
            end
         end
         default: state_d = DCD_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= DCD_IDLE;
         cmd_q   <= '0;
         dec_q   <= '0;
         dv_q    <= 1'b0;
         set_q   <= DCD_SET_RESET;
         st_q    <= DCD_ST_READY;
         er_q    <= '0;
         cnt_q   <= '0;
         dh_q    <= '0;
         irq_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         cmd_q   <= cmd_d;
         dec_q   <= dec_d;
         dv_q    <= dv_d;
         set_q   <= set_d;
         st_q    <= st_d;
         er_q    <= er_d;
         cnt_q   <= cnt_d;
         dh_q    <= dh_d;
         irq_q   <= irq_d;
      end
   end

   logic busy_q;
   logic busy_d;

   // busy follows the next state, so it falls in the same cycle as irq
   always_comb begin
      busy_d = (state_d != DCD_IDLE);
   end

   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= busy_d;
      end
   end

   assign dec         = dec_q;
   assign dec_valid   = dv_q;
   assign busy        = busy_q;
   assign settings    = set_q;
   assign status      = st_q;
   assign error       = er_q;
   assign count_out   = cnt_q;
   assign devhead_out = dh_q;
   assign irq         = irq_q;

   // ==========================================================
   // checks
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n_q);

   a_seek_nibble: assert property (
      dv_q && cmd_q.opcode[7:4] == DCD_OP_SEEK_HI
      |-> dec_q.seek && !dec_q.abort)
      else $error("seek opcode not decoded");

   a_alt_sleep: assert property (
      dv_q && (cmd_q.opcode == 8'h99 || cmd_q.opcode == 8'he6)
      |-> dec_q.cls == DCD_CLS_NODATA)
      else $error("sleep alternate misclassified");

   a_write_dma: assert property (
      dv_q && (cmd_q.opcode == 8'h3d || cmd_q.opcode == 8'h35)
      |-> dec_q.cls == DCD_CLS_DMA)
      else $error("write dma misclassified");

   a_fpdma_cls: assert property (
      dv_q && cmd_q.opcode == 8'h61
      |-> dec_q.cls == DCD_CLS_FPDMA)
      else $error("queued write misclassified");

   a_retry_same: assert property (
      dv_q && (cmd_q.opcode == 8'h20 || cmd_q.opcode == 8'h21)
      |-> dec_q.cls == DCD_CLS_PIO_IN)
      else $error("retry bit changed the class");

   a_health_in: assert property (
      dv_q && cmd_q.opcode == DCD_OP_HEALTH && cmd_q.feature == DCD_HS_RD_LOG
      |-> dec_q.cls == DCD_CLS_PIO_IN)
      else $error("health log read not data in");

   a_health_on: assert property (
      state_q == DCD_DECODE && dec_w.hs_op && cmd_q.feature == DCD_HS_ENABLE
      |=> set_q[DCD_SET_HLTH])
      else $error("health monitoring not enabled");

   a_apm_set: assert property (
      state_q == DCD_DECODE && !dec_w.abort && cmd_q.opcode == DCD_OP_FEATURES
      && cmd_q.feature == DCD_FS_APM_EN |=> set_q[DCD_SET_APM])
      else $error("power management not enabled");

   a_aam_off: assert property (
      state_q == DCD_DECODE && cmd_q.opcode == DCD_OP_FEATURES
      && cmd_q.feature == DCD_FS_AAM_DIS |=> !set_q[DCD_SET_AAM])
      else $error("acoustic management not disabled");

   a_rla_off: assert property (
      state_q == DCD_DECODE && cmd_q.opcode == DCD_OP_FEATURES
      && cmd_q.feature == DCD_FS_RLA_DIS |=> !set_q[DCD_SET_RLA])
      else $error("look-ahead not disabled");

   a_wc_on: assert property (
      state_q == DCD_DECODE && cmd_q.opcode == DCD_OP_FEATURES
      && cmd_q.feature == DCD_FS_WC_EN |=> set_q[DCD_SET_WC])
      else $error("write cache not enabled");

   a_abort_err: assert property (
      dv_q && dec_q.abort
      |-> irq_q && er_q == DCD_ERR_ABORT)
      else $error("abort not flagged");

   a_irq_status: assert property (
      irq_q
      |-> (st_q & DCD_ST_READY) == DCD_ST_READY && $past(state_q) != DCD_IDLE)
      else $error("completion without status");

   a_irq_pulse: assert property (
      irq_q
      |=> !irq_q)
      else $error("completion pulse too long");

   a_busy_clear: assert property (
      irq_q
      |-> !busy_q)
      else $error("busy still set at completion");

   a_final_hold: assert property (
      !irq_q
      |-> $stable(st_q) && $stable(er_q) && $stable(cnt_q) && $stable(dh_q))
      else $error("result registers changed without completion");

   a_dev_zero: assert property (
      irq_q && er_q != DCD_ERR_ABORT
      |-> !dh_q[DCD_DH_DEV_BIT])
      else $error("device bit returned");

   c_abort: cover property (dv_q && dec_q.abort);
   c_feature: cover property (dv_q && cmd_q.opcode == DCD_OP_FEATURES ##[1:20] irq_q);
   c_health: cover property (dv_q && dec_q.hs_op && !dec_q.abort);
   c_dma: cover property (dv_q && dec_q.cls == DCD_CLS_DMA ##[1:20] irq_q);

endmodule

// ---- tb/dcd_host_model.sv ----
`timescale 1ns/100ps
// ==========================================================
// host side: issues one command at a time, plays execution
module dcd_host_model
   import dcd_pkg::*;
(
   input  wire logic       clock,
   output logic            cmd_valid,
   output dcd_cmd_t        cmd,
   output logic [7:0]      result_count,
   output logic            done,
   input  wire dcd_dec_t   dec,
   input  wire logic       dec_valid,
   input  wire logic       busy,
   input  wire logic [7:0] settings,
   input  wire logic [7:0] status,
   input  wire logic [7:0] error,
   input  wire logic [7:0] count_out,
   input  wire logic [7:0] devhead_out,
   input  wire logic       irq
);
   dcd_dec_t   got_dec;
   logic [7:0] got_set, mid_st, got_st, got_err, got_cnt, got_dh;
   logic       ok, dv_irq, idle_seen;

   initial begin
      cmd_valid    = 1'b0;
      cmd          = 24'h5a3c96;
      result_count = 8'h3c;
      done         = 1'b0;
   end

   // ==========================================================
   // one command; lag stretches execution, poke tries a second command while busy
   task automatic issue(input logic [7:0] op, fe, dh, rc, input int lag, input bit poke);
      int n;
      ok = 1'b0;
      @(negedge clock);
      cmd       = {op, fe, dh | 8'ha0}; // parameters and fixed bits 7, 5 set with the strobe
      cmd_valid = 1'b1;
      @(negedge clock);
      cmd_valid = 1'b0;
      cmd       = ~cmd; // no stale copy left on released lines
      for (n = 0; n < 4 && dec_valid !== 1'b1; n++) begin
         @(posedge clock);
         #1;
      end
      if (dec_valid !== 1'b1) return;
      got_dec = dec;
      got_set = settings;
      mid_st  = status;
      dv_irq  = irq;
      if (irq !== 1'b1) begin
         if (poke) begin
            @(negedge clock);
            cmd       = {8'hff, 16'h0000};
            cmd_valid = 1'b1;
            @(negedge clock);
            cmd_valid = 1'b0;
            cmd       = ~cmd;
         end
         repeat (lag) @(negedge clock);
         @(negedge clock);
         done         = 1'b1;
         result_count = rc;
         @(negedge clock);
         done         = 1'b0;
         result_count = ~rc;
         for (n = 0; n < 4 && irq !== 1'b1; n++) begin
            @(posedge clock);
            #1;
         end
      end
      if (irq !== 1'b1) return;
      got_st  = status;
      got_err = error;
      got_cnt = count_out;
      got_dh  = devhead_out;
      ok      = 1'b1;
   endtask

   // a completion pulse with nothing running must leave the block quiet
   task automatic idle_done();
      idle_seen = 1'b0;
      @(negedge clock);
      done = 1'b1;
      @(negedge clock);
      done = 1'b0;
      repeat (4) begin
         @(posedge clock);
         #1;
         idle_seen = idle_seen | irq | dec_valid | busy;
      end
   endtask
endmodule

// ---- tb/test_disk_command_opcode_decoder.sv ----
`timescale 1ns/100ps
module test_disk_command_opcode_decoder
   import dcd_pkg::*;
;
   logic       clock, nrst, cmd_valid, done, dec_valid, busy, irq;
   dcd_cmd_t   cmd;
   dcd_dec_t   dec, got;
   logic [7:0] result_count, settings, status, error, count_out, devhead_out, exp_set;
   int         num_errors, samples_checked, cycles;

   // opcode, feature, class packed as hex digits: oo ff c
   localparam logic [19:0] OPS [42] = '{
      20'he6003, 20'h99003, 20'he2003, 20'h96003, 20'he0003, 20'h94003, 20'he5003, 20'h98003,
      20'he3003, 20'h97003, 20'he1003, 20'h95003, 20'hce002, 20'h3d004, 20'h35004, 20'hca004,
      20'hcb004, 20'h30002, 20'h31002, 20'h34002, 20'hc5002, 20'h39002, 20'h3f002, 20'h20001,
      20'h21001, 20'hc8004, 20'h60005, 20'h61005, 20'h70003, 20'h7f003, 20'h7a003, 20'hb0d83,
      20'hb0d01, 20'hb0d11, 20'hb0d51, 20'hb0d62, 20'hb0d23, 20'hb0d33, 20'hb0d43, 20'hb0da3,
      20'hb0db3, 20'hb0d93};
   // feature subcode, settings bit, new value
   localparam logic [15:0] SETS [14] = '{16'h0201, 16'h8200, 16'h0511, 16'h8510, 16'h4221,
      16'hc220, 16'h5530, 16'haa31, 16'h6640, 16'hcc41, 16'h0651, 16'h8650, 16'h0961, 16'h8960};
   localparam logic [15:0] BAD [4] = '{16'hff00, 16'hb0d7, 16'hef00, 16'hb0dc};

   dcd_decoder i_dcd_decoder (.clock(clock), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd),
      .result_count(result_count), .done(done), .dec(dec), .dec_valid(dec_valid), .busy(busy),
      .settings(settings), .status(status), .error(error), .count_out(count_out),
      .devhead_out(devhead_out), .irq(irq));
   dcd_host_model i_dcd_host_model (.clock(clock), .cmd_valid(cmd_valid), .cmd(cmd),
      .result_count(result_count), .done(done), .dec(dec), .dec_valid(dec_valid), .busy(busy),
      .settings(settings), .status(status), .error(error), .count_out(count_out),
      .devhead_out(devhead_out), .irq(irq));

   initial clock = 1'b0;
   always #25 clock = ~clock;

   // ==========================================================
   // checking and closing
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // whole run is well under a thousand cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         conclude();
      end
   end

   // ==========================================================
   // one command with its common checks
   task automatic run(input logic [7:0] op, fe, dh, input logic [2:0] cls, input logic ab, input int lag);
      i_dcd_host_model.issue(op, fe, dh, 8'h5a ^ op, lag, 1'b0);
      got = i_dcd_host_model.got_dec;
      check("handshake", 8'(i_dcd_host_model.ok), 8'h01);
      check("abort", 8'(got.abort), 8'(ab));
      if (!ab) check("class", 8'(got.cls), 8'(cls));
      check("status", i_dcd_host_model.got_st, ab ? 8'h41 : 8'h40);
      check("error", i_dcd_host_model.got_err, ab ? 8'h04 : 8'h00);
      check("irq with decode", 8'(i_dcd_host_model.dv_irq), 8'(ab));
      check("settings", i_dcd_host_model.got_set, exp_set);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      nrst            = 1'b0;
      num_errors      = 0;
      samples_checked = 0;
      cycles          = 0;
      exp_set         = 8'h18;
      repeat (16) @(negedge clock);
      nrst = 1'b1;
      repeat (3) @(negedge clock);
      check("reset status", status, 8'h40);
      check("reset settings", settings, 8'h18);
      check("reset error", error, 8'h00);
      check("reset idle", {5'h0, busy, irq, dec_valid}, 8'h00);
      // monitoring enabled first, disabled by the last entry
      foreach (OPS[i]) begin
         if (OPS[i][19:4] == 16'hb0d8) exp_set[7] = 1'b1;
         if (OPS[i][19:4] == 16'hb0d9) exp_set[7] = 1'b0;
         run(OPS[i][19:12], OPS[i][11:4], 8'h00, OPS[i][2:0], 1'b0, i % 3);
         check("seek flag", 8'(got.seek), 8'(OPS[i][19:16] == 4'h7));
         check("health op", 8'(got.hs_op), 8'(OPS[i][19:12] == 8'hb0));
      end
      foreach (SETS[i]) begin
         exp_set[SETS[i][7:4]] = SETS[i][0];
         run(8'hef, SETS[i][15:8], 8'h00, 3'h3, 1'b0, 1);
      end
      run(8'hef, 8'h07, 8'h00, 3'h3, 1'b0, 0);
      check("spin-up", 8'(got.spinup), 8'h01);
      run(8'hef, 8'h03, 8'h00, 3'h3, 1'b0, 0);
      check("transfer mode", 8'(got.xfer_mode), 8'h01);
      // error status holds until the next completion
      foreach (BAD[i]) begin
         run(BAD[i][15:8], BAD[i][7:0], 8'h00, 3'h0, 1'b1, 0);
         run(8'h20, 8'h00, 8'h00, 3'h1, 1'b0, 0);
         check("status held", i_dcd_host_model.mid_st, 8'h41);
      end
      run(8'h20, 8'h00, 8'h55, 3'h1, 1'b0, 2);
      check("lba", 8'(got.lba), 8'h01);
      check("head", 8'(got.head), 8'h05);
      check("devhead", i_dcd_host_model.got_dh, 8'he5);
      check("count", i_dcd_host_model.got_cnt, 8'h7a);
      run(8'h21, 8'h00, 8'h13, 3'h1, 1'b0, 0);
      check("chs", 8'(got.lba), 8'h00);
      check("head", 8'(got.head), 8'h03);
      check("devhead", i_dcd_host_model.got_dh, 8'ha3);
      check("count", i_dcd_host_model.got_cnt, 8'h7b);
      // a command offered while busy is dropped; a taken one would abort and lose the completion
      i_dcd_host_model.issue(8'h20, 8'h00, 8'h00, 8'h11, 1, 1'b1);
      check("busy handshake", 8'(i_dcd_host_model.ok), 8'h01);
      check("busy refusal", i_dcd_host_model.got_st, 8'h40);
      check("busy refusal count", i_dcd_host_model.got_cnt, 8'h11);
      i_dcd_host_model.idle_done();
      check("quiet after refusal", 8'(i_dcd_host_model.idle_seen), 8'h00);
      conclude();
   end
endmodule
